// File: logic/ccs_charge_cycle_sequencer.v
// charge cycle sequencer: trickle, constant current, constant voltage, status latch
// assumes clk_i is the internal oscillator, sys_rst_i is the power-on comparator
//
// Notes on behaviour
// - each charge cycle starts in trickle at 10 percent current
// - trickle ends after 15 consecutive oscillator cycles above minimum level
// - after trickle, constant current then constant voltage regulation
// - status pin pulled low from cycle start until end of charge qualifies
// - end of charge needs battery above recharge level and current below eoc level
// - on end of charge status is released high and latched
// - latch cleared by recharge start, enable toggle, or power cycle
// - after end of charge, battery below recharge level restarts charging and pulls status low
// - power-on clears counters and latch, holds off with status released until enable is seen
// - power-present output active only while supply above power-on level
// - over-temperature reduces commanded charge current
// - minimum level dropping during qualification restarts the count
// - low current ignored for 16 cycles after battery exceeds recharge level
// - enable released from low starts new cycle; enable low disables
// - switch to constant voltage when final charge voltage reached
`timescale 1ns/1ps
`default_nettype none
`include "ccs_map.vh"
module ccs_charge_cycle_sequencer (
  input  wire       clk_i,
  input  wire       sys_rst_i,
  input  wire       ce_i,
  input  wire       enable_i,
  input  wire       above_min_fast_charge_level_i,
  input  wire       above_recharge_level_i,
  input  wire       below_eoc_current_level_i,
  input  wire       at_final_charge_voltage_i,
  input  wire       die_over_temp_i,
  input  wire       supply_above_por_i,
  output reg        power_present_out_o,
  output reg        status_out_o,
  output reg        status_oe_o,
  output reg  [6:0] charge_current_pct_o,
  output reg        mode_trickle_o,
  output reg        mode_cc_o,
  output reg        mode_cv_o,
  output reg        eoc_latched_o
);

  // ****************************************************************
  // flag synchronisation
  // ****************************************************************
  wire [5:0] flags_s;
  wire       min_s;
  wire       rechg_s;
  wire       ilow_s;
  wire       vch_s;
  wire       hot_s;
  wire       en_s;

  ccs_sync #(
    .WIDTH (6)
  ) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .async_i   ({enable_i, die_over_temp_i, at_final_charge_voltage_i,
                 below_eoc_current_level_i, above_recharge_level_i,
                 above_min_fast_charge_level_i}),
    .sync_o    (flags_s)
  );

  assign min_s   = flags_s[0];
  assign rechg_s = flags_s[1];
  assign ilow_s  = flags_s[2];
  assign vch_s   = flags_s[3];
  assign hot_s   = flags_s[4];
  assign en_s    = flags_s[5];

  // ****************************************************************
  // sequencing state
  // ****************************************************************
  reg  [4:0] state_ff;
  reg  [4:0] nxt_state;
  reg  [4:0] qual_cnt_ff;
  reg  [4:0] nxt_qual_cnt;
  reg  [4:0] blank_cnt_ff;
  reg  [4:0] nxt_blank_cnt;
  reg        eoc_ff;
  reg        nxt_eoc;
  reg        en_d_ff;
  reg        rechg_d_ff;
  wire       en_rise;
  wire       rechg_fall;
  wire       blank_done;

  assign en_rise    = en_s & ~en_d_ff;
  assign rechg_fall = rechg_d_ff & ~rechg_s;
  assign blank_done = (blank_cnt_ff == `CCS_EOC_BLANK);

  always @*
  begin
    nxt_state     = state_ff;
    nxt_qual_cnt  = qual_cnt_ff;
    nxt_blank_cnt = blank_cnt_ff;
    nxt_eoc       = eoc_ff;
    // blanking count restarts whenever battery is below recharge level
    if (!rechg_s)
      nxt_blank_cnt = `CCS_RST_CNT;
    else if (!blank_done)
      nxt_blank_cnt = blank_cnt_ff + 5'h01;
    case (state_ff)
      `CCS_ST_OFF:
      begin
        nxt_eoc      = 1'b0;
        nxt_qual_cnt = `CCS_RST_CNT;
        if (en_s)
          nxt_state = `CCS_ST_TRICKLE;
      end
      `CCS_ST_TRICKLE:
      begin
        if (!min_s)
          nxt_qual_cnt = `CCS_RST_CNT;
        else if (qual_cnt_ff == `CCS_QUAL_CYCLES - 5'h01)
        begin
          nxt_qual_cnt = `CCS_RST_CNT;
          nxt_state    = `CCS_ST_CC;
        end
        else
          nxt_qual_cnt = qual_cnt_ff + 5'h01;
      end
      `CCS_ST_CC:
      begin
        if (vch_s)
          nxt_state = `CCS_ST_CV;
      end
      `CCS_ST_CV:
      begin
        // regulation continues after end of charge
        if (rechg_s && ilow_s && blank_done)
          nxt_eoc = 1'b1;
      end
      default:
        nxt_state = `CCS_ST_OFF;
    endcase
    // recharge: battery falls below recharge level after charge completed
    if (eoc_ff && rechg_fall && state_ff != `CCS_ST_OFF)
    begin
      nxt_eoc      = 1'b0;
      nxt_qual_cnt = `CCS_RST_CNT;
      nxt_state    = `CCS_ST_TRICKLE;
    end
    if (en_rise)
    begin
      nxt_eoc      = 1'b0;
      nxt_qual_cnt = `CCS_RST_CNT;
      nxt_state    = `CCS_ST_TRICKLE;
    end
    if (!en_s)
    begin
      nxt_state = `CCS_ST_OFF;
      nxt_eoc   = 1'b0;
    end
  end

  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      // power-on starts a fresh cycle once enable is seen
      state_ff     <= `CCS_ST_OFF;
      qual_cnt_ff  <= `CCS_RST_CNT;
      blank_cnt_ff <= `CCS_RST_CNT;
      eoc_ff       <= 1'b0;
      en_d_ff      <= 1'b0;
      rechg_d_ff   <= 1'b0;
    end
    else if (ce_i)
    begin
      state_ff     <= nxt_state;
      qual_cnt_ff  <= nxt_qual_cnt;
      blank_cnt_ff <= nxt_blank_cnt;
      eoc_ff       <= nxt_eoc;
      en_d_ff      <= en_s;
      rechg_d_ff   <= rechg_s;
    end
  end

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  function [6:0] cur_pct;
    input [4:0] st;
    input       hot;
    reg   [6:0] base;
    begin
      base = `CCS_I_ZERO;
      case (st)
        `CCS_ST_TRICKLE: base = `CCS_I_TRICKLE;
        `CCS_ST_CC:      base = `CCS_I_FULL;
        `CCS_ST_CV:      base = `CCS_I_FULL;
        default:         base = `CCS_I_ZERO;
      endcase
      if (hot && base > `CCS_I_FOLD)
        base = `CCS_I_FOLD;
      else if (hot)
        base = {1'b0, base[6:1]};
      cur_pct = base;
    end
  endfunction

  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      power_present_out_o  <= 1'b0;
      status_out_o         <= 1'b0;
      status_oe_o          <= 1'b0;
      charge_current_pct_o <= `CCS_I_ZERO;
      mode_trickle_o       <= 1'b0;
      mode_cc_o            <= 1'b0;
      mode_cv_o            <= 1'b0;
      eoc_latched_o        <= 1'b0;
    end
    else if (ce_i)
    begin
      power_present_out_o  <= supply_above_por_i;
      status_out_o         <= 1'b0;
      // pulled low while charging and not yet end of charge
      status_oe_o          <= (nxt_state != `CCS_ST_OFF) && !nxt_eoc;
      charge_current_pct_o <= cur_pct(nxt_state, hot_s);
      mode_trickle_o       <= (nxt_state == `CCS_ST_TRICKLE);
      mode_cc_o            <= (nxt_state == `CCS_ST_CC);
      mode_cv_o            <= (nxt_state == `CCS_ST_CV);
      eoc_latched_o        <= nxt_eoc;
    end
  end

endmodule
`default_nettype wire

// File: logic/ccs_map.vh
// constants for the charge cycle sequencer: mode codes, counts, current levels
// assumes inclusion by bare name from the sequencer files
`ifndef CCS_MAP_VH
`define CCS_MAP_VH

// one-hot mode codes
`define CCS_ST_OFF      5'h01
`define CCS_ST_TRICKLE  5'h02
`define CCS_ST_CC       5'h04
`define CCS_ST_CV       5'h08
`define CCS_ST_IDLE     5'h10

// oscillator-cycle counts
`define CCS_QUAL_CYCLES 5'h0F
`define CCS_EOC_BLANK   5'h10

// commanded current, percent of programmed current
`define CCS_I_FULL      7'h64
`define CCS_I_TRICKLE   7'h0A
`define CCS_I_FOLD      7'h32
`define CCS_I_ZERO      7'h00

// reset values
`define CCS_RST_CNT     5'h00
`define CCS_RST_SYNC    6'h00

`endif

// File: logic/ccs_sync.v
// two-stage synchroniser bank for the comparator flags
// assumes flags are asynchronous levels from analog comparators
`timescale 1ns/1ps
`default_nettype none
module ccs_sync #(
  parameter WIDTH = 6
) (
  input  wire             clk_i,
  input  wire             sys_rst_i,
  input  wire             ce_i,
  input  wire [WIDTH-1:0] async_i,
  output reg  [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_ff;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_bit
      always @(posedge clk_i)
      begin
        if (sys_rst_i)
        begin
          meta_ff[g] <= 1'b0;
          sync_o[g]  <= 1'b0;
        end
        else if (ce_i)
        begin
          meta_ff[g] <= async_i[g];
          sync_o[g]  <= meta_ff[g];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// File: sim/ccs_chk.sv
// port checker for the charge cycle sequencer
// assumes one clock, ce_i held high by the bench
`timescale 1ns/1ps
`default_nettype none
module ccs_chk (
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic       enable_i,
  input wire logic       above_min_fast_charge_level_i,
  input wire logic       above_recharge_level_i,
  input wire logic       below_eoc_current_level_i,
  input wire logic       at_final_charge_voltage_i,
  input wire logic       die_over_temp_i,
  input wire logic       supply_above_por_i,
  input wire logic       power_present_out_o,
  input wire logic       status_out_o,
  input wire logic       status_oe_o,
  input wire logic [6:0] charge_current_pct_o,
  input wire logic       mode_trickle_o,
  input wire logic       mode_cc_o,
  input wire logic       mode_cv_o,
  input wire logic       eoc_latched_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_off; !enable_i[*4]; endsequence
  sequence s_steady; (enable_i && above_recharge_level_i)[*4] ##0 eoc_latched_o; endsequence
  property p_pp; !sys_rst_i |=> power_present_out_o == $past(supply_above_por_i); endproperty
  property p_tr; !die_over_temp_i[*4] ##0 mode_trickle_o |-> charge_current_pct_o == 7'h0A;
  endproperty
  property p_qual; $rose(mode_cc_o) |-> $past(mode_trickle_o, 15)
    && $past(above_min_fast_charge_level_i, 12); endproperty
  property p_cv; $rose(mode_cv_o) |-> $past(mode_cc_o) && $past(at_final_charge_voltage_i, 3);
  endproperty
  property p_oe; !status_out_o
    && status_oe_o == (!eoc_latched_o && (mode_trickle_o || mode_cc_o || mode_cv_o)); endproperty
  property p_eoc; $rose(eoc_latched_o) |-> mode_cv_o && $past(below_eoc_current_level_i, 3)
    && $past(above_recharge_level_i, 3) && $past(above_recharge_level_i, 17); endproperty
  property p_hold; s_steady |=> eoc_latched_o && mode_cv_o; endproperty
  property p_off; s_off |-> charge_current_pct_o == 7'h00 && !status_oe_o && !eoc_latched_o;
  endproperty
  property p_hot; die_over_temp_i[*4] ##0 mode_cc_o |-> charge_current_pct_o == 7'h32;
  endproperty
  property p_rechg; (eoc_latched_o && $fell(above_recharge_level_i)) ##1
    !above_recharge_level_i[*3] |-> ##[0:2] mode_trickle_o && status_oe_o; endproperty
  a_pp: assert property (p_pp) else $error("power present does not follow supply");
  a_tr: assert property (p_tr) else $error("trickle current wrong");
  a_qual: assert property (p_qual) else $error("left trickle early");
  a_cv: assert property (p_cv) else $error("bad entry to voltage mode");
  a_oe: assert property (p_oe) else $error("status drive wrong");
  a_eoc: assert property (p_eoc) else $error("end of charge unqualified");
  a_hold: assert property (p_hold) else $error("latch lost");
  a_off: assert property (p_off) else $error("disabled charger active");
  a_hot: assert property (p_hot) else $error("no foldback");
  a_rechg: assert property (p_rechg) else $error("no recharge start");
endmodule
bind ccs_charge_cycle_sequencer ccs_chk u_chk (.*);
`default_nettype wire

// File: sim/ccs_batt.sv
// battery model: voltage climbs while current is commanded
// assumes the sequencer clock; drain_i drops it under recharge level
// min_block_i hides the minimum level, ilow_force_i shows low current early
`timescale 1ns/1ps
`default_nettype none
module ccs_batt (
  input  wire logic       clk_i,
  input  wire logic [6:0] pct_i,
  input  wire logic       drain_i,
  input  wire logic       min_block_i,
  input  wire logic       ilow_force_i,
  output wire logic       min_o,
  output wire logic       rechg_o,
  output wire logic       fin_o,
  output wire logic       ilow_o
);
  logic [7:0] v_ff = 8'h00;
  always @(posedge clk_i)
    if (drain_i)
      v_ff <= 8'h50;
    else if (pct_i != 7'h00 && v_ff != 8'hC8)
      v_ff <= v_ff + 8'h01;
  assign min_o   = (v_ff > 8'h14) && !min_block_i;
  assign rechg_o = v_ff > 8'h64;
  assign fin_o   = v_ff > 8'h95;
  assign ilow_o  = (v_ff > 8'hB3) || ilow_force_i;
endmodule
`default_nettype wire

// File: sim/test_ccs_charge_cycle_sequencer.sv
// self-checking bench for the charge cycle sequencer
// assumes battery model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module test_ccs_charge_cycle_sequencer;
  logic clk = 1'b0, rst = 1'b1, en = 1'b0, hot = 1'b0, por = 1'b1, drain = 1'b0;
  logic blk = 1'b0, frc = 1'b0;
  wire logic mn, rc, fin, il, pp, st, oe, tr, cc, cv, eoc;
  wire logic [6:0] pct;
  int bad_count = 0;
  int n_compared = 0;
  always #5 clk = ~clk;
  ccs_batt u_batt (.clk_i(clk), .pct_i(pct), .drain_i(drain), .min_block_i(blk),
    .ilow_force_i(frc), .min_o(mn), .rechg_o(rc),
    .fin_o(fin), .ilow_o(il));
  ccs_charge_cycle_sequencer dut (.clk_i(clk), .sys_rst_i(rst), .ce_i(1'b1), .enable_i(en),
    .above_min_fast_charge_level_i(mn), .above_recharge_level_i(rc),
    .below_eoc_current_level_i(il), .at_final_charge_voltage_i(fin), .die_over_temp_i(hot),
    .supply_above_por_i(por), .power_present_out_o(pp), .status_out_o(st), .status_oe_o(oe),
    .charge_current_pct_o(pct), .mode_trickle_o(tr), .mode_cc_o(cc), .mode_cv_o(cv),
    .eoc_latched_o(eoc));
  task summarize();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  // wait for {eoc, trickle, cc, cv}
  task wst(input logic [3:0] m);
    int i;
    for (i = 0; i < 400 && {eoc, tr, cc, cv} !== m; i++)
      @(negedge clk);
    chk("mode", {4'h0, m}, {4'h0, eoc, tr, cc, cv});
    if (i == 400)
      summarize();
  endtask
  task t_por();
    repeat (3) @(negedge clk);
    chk("reset current", 8'h00, {1'b0, pct});
    chk("reset pins", 8'h00, {5'h00, pp, oe, st});
    @(posedge clk) rst <= 1'b0;
    repeat (2) @(negedge clk);
    chk("power present", 8'h01, {7'h00, pp});
    @(posedge clk) por <= 1'b0;
    repeat (2) @(negedge clk);
    chk("power gone", 8'h00, {7'h00, pp});
    @(posedge clk) por <= 1'b1;
    $display("t_por done");
  endtask
  task t_charge();
    int i;
    @(posedge clk) en <= 1'b1;
    wst(4'b0100);
    chk("trickle", 8'h8A, {oe, pct});
    chk("status data", 8'h00, {7'h00, st});
    wst(4'b0010);
    chk("cc current", 8'h64, {1'b0, pct});
    @(posedge clk) hot <= 1'b1;
    repeat (5) @(negedge clk);
    chk("foldback", 8'h32, {1'b0, pct});
    @(posedge clk) hot <= 1'b0;
    wst(4'b0001);
    // drop under recharge level, then show low current before it climbs back
    @(posedge clk) drain <= 1'b1;
    @(posedge clk) drain <= 1'b0;
    @(posedge clk) frc <= 1'b1;
    for (i = 0; i < 400 && rc !== 1'b1; i++)
      @(negedge clk);
    chk("recharge level", 8'h01, {7'h00, rc});
    if (i == 400)
      summarize();
    repeat (16) @(negedge clk);
    chk("eoc blanked", 8'h01, {4'h0, eoc, tr, cc, cv});
    wst(4'b1001);
    @(posedge clk) frc <= 1'b0;
    chk("eoc status", 8'h00, {7'h00, oe});
    $display("t_charge done");
  endtask
  task t_recharge();
    @(posedge clk) drain <= 1'b1;
    @(posedge clk) drain <= 1'b0;
    wst(4'b0100);
    chk("recharge status", 8'h01, {7'h00, oe});
    wst(4'b1001);
    $display("t_recharge done");
  endtask
  task t_enable();
    @(posedge clk) en <= 1'b0;
    wst(4'b0000);
    chk("off current", 8'h00, {oe, pct});
    @(posedge clk) en <= 1'b1;
    wst(4'b0100);
    // one low sample of the minimum level in mid-count restarts qualification
    repeat (8) @(negedge clk);
    @(posedge clk) blk <= 1'b1;
    @(posedge clk) blk <= 1'b0;
    repeat (15) @(negedge clk);
    chk("qual restart", 8'h04, {4'h0, eoc, tr, cc, cv});
    wst(4'b0010);
    $display("t_enable done");
  endtask
  initial
  begin
    t_por();
    t_charge();
    t_recharge();
    t_enable();
    summarize();
  end
endmodule
`default_nettype wire
